// ==== bench/counter_array_timebase_tb.sv ====
`timescale 1ns/1ns
`include "counter_array_defs.svh"

module counter_array_timebase_tb;
	logic        clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        timer0_overflow;
	logic        external_count_input;
	logic        ext_osc_clk;
	logic        rtc_osc_clk;
	logic        cpu_idle;
	logic [15:0] count_value;
	logic        watchdog_mode;
	logic        irq_request;
	logic [7:0]  cyc_ff;
	logic [31:0] rd;
	logic        err;
	logic [15:0] c0;
	int          t;
	int          gap;
	int          cycles;
	int          miscompares;
	int          n_checks;
	// Expected tick spacing per select code
	int          per_tab [8] = '{12, 4, 8, 16, 1, 32, 64, 0};

	counter_array_timebase DUT (
		.clk                  (clk),
		.rst                  (rst),
		.psel                 (psel),
		.penable              (penable),
		.pwrite               (pwrite),
		.paddr                (paddr),
		.pwdata               (pwdata),
		.prdata               (prdata),
		.pready               (pready),
		.pslverr              (pslverr),
		.timer0_overflow      (timer0_overflow),
		.external_count_input (external_count_input),
		.ext_osc_clk          (ext_osc_clk),
		.rtc_osc_clk          (rtc_osc_clk),
		.cpu_idle             (cpu_idle),
		.count_value          (count_value),
		.watchdog_mode        (watchdog_mode),
		.irq_request          (irq_request)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	// Free-running sources: osc /4 and /8, count pin /16, timer0 /8
	// count pin within sysclk/4
	always @(posedge clk) begin
		if (rst) begin
			cyc_ff <= 8'h00;
			ext_osc_clk <= 1'b0;
			rtc_osc_clk <= 1'b0;
			external_count_input <= 1'b1;
			timer0_overflow <= 1'b0;
		end else begin
			cyc_ff <= cyc_ff + 8'h01;
			ext_osc_clk <= cyc_ff[1];
			rtc_osc_clk <= cyc_ff[2];
			external_count_input <= cyc_ff[3];
			timer0_overflow <= (cyc_ff[2:0] == 3'h5);
		end
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	task automatic check(input string name, input logic [31:0] seen,
			input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic apb(input logic w, input logic [7:0] a,
			input logic [7:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check("pready", {31'h0, pready}, 32'h1);
	endtask : apb

	// Cycles between two successive counter changes, 0 if none
	task automatic measure(output int g);
		logic [15:0] prev;
		int n;
		g = 0;
		n = 0;
		@(negedge clk);
		prev = count_value;
		while (count_value === prev && n < 200) begin
			@(negedge clk);
			n++;
		end
		if (n == 200)
			return;
		prev = count_value;
		do begin
			@(negedge clk);
			g++;
		end while (count_value === prev && g < 200);
	endtask : measure

	task automatic settle;
		repeat (2) @(negedge clk);
	endtask : settle

	////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		cpu_idle = 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check("wdt after reset", {31'h0, watchdog_mode}, 32'h1);
		check("irq after reset", {31'h0, irq_request}, 32'h0);
		apb(1'b0, `CA_ADDR_MODE, 8'h00);
		check("mode reset", rd, 32'h40);
		apb(1'b1, `CA_ADDR_MODE, 8'h48);
		apb(1'b0, `CA_ADDR_MODE, 8'h00);
		check("mode locked", rd, 32'h40);
		apb(1'b0, 8'h14, 8'h00);
		check("unmapped err", {31'h0, err}, 32'h1);
		check("unmapped data", rd, 32'h0);
		apb(1'b1, `CA_ADDR_MODE, 8'h00);
		@(negedge clk);
		check("wdt off", {31'h0, watchdog_mode}, 32'h0);
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, `CA_ADDR_MODE, {4'h0, i[2:0], 1'b0});
			measure(gap);
			check("tick gap", gap, per_tab[i]);
		end
		apb(1'b1, `CA_ADDR_CNT_HIGH, 8'h12);
		apb(1'b1, `CA_ADDR_CNT_LOW, 8'hFE);
		apb(1'b0, `CA_ADDR_CNT_LOW, 8'h00);
		check("low byte", rd, 32'hFE);
		apb(1'b1, `CA_ADDR_CNT_HIGH, 8'h55);
		@(negedge clk);
		check("live count", {16'h0, count_value}, 32'h55FE);
		apb(1'b0, `CA_ADDR_CNT_HIGH, 8'h00);
		check("high snapshot", rd, 32'h12);
		apb(1'b1, `CA_ADDR_MODE, 8'h08);
		@(negedge clk);
		c0 = count_value;
		t = cycles;
		repeat (3) apb(1'b0, `CA_ADDR_CNT_LOW, 8'h00);
		@(negedge clk);
		check("run in reads", 32'(count_value - c0), 32'(cycles - t));
		apb(1'b1, `CA_ADDR_CNT_HIGH, 8'hFF);
		apb(1'b1, `CA_ADDR_CNT_LOW, 8'hF0);
		apb(1'b1, `CA_ADDR_EXT_IE, 8'h01);
		apb(1'b1, `CA_ADDR_IE, 8'h80);
		repeat (30) @(negedge clk);
		check("irq no ecf", {31'h0, irq_request}, 32'h0);
		apb(1'b0, `CA_ADDR_MODE, 8'h00);
		check("flag set", rd, 32'h28);
		apb(1'b1, `CA_ADDR_MODE, 8'h29);
		settle();
		check("irq on", {31'h0, irq_request}, 32'h1);
		apb(1'b1, `CA_ADDR_IE, 8'h00);
		settle();
		check("irq no global", {31'h0, irq_request}, 32'h0);
		apb(1'b1, `CA_ADDR_IE, 8'h80);
		apb(1'b1, `CA_ADDR_EXT_IE, 8'h00);
		settle();
		check("irq no array", {31'h0, irq_request}, 32'h0);
		apb(1'b1, `CA_ADDR_EXT_IE, 8'h01);
		settle();
		check("irq both", {31'h0, irq_request}, 32'h1);
		apb(1'b1, `CA_ADDR_MODE, 8'h09);
		settle();
		check("irq cleared", {31'h0, irq_request}, 32'h0);
		apb(1'b0, `CA_ADDR_MODE, 8'h00);
		check("flag cleared", rd, 32'h09);
		@(posedge clk);
		cpu_idle <= 1'b1;
		measure(gap);
		check("idle runs", gap, 1);
		apb(1'b1, `CA_ADDR_MODE, 8'h88);
		@(negedge clk);
		c0 = count_value;
		repeat (10) @(negedge clk);
		check("idle hold", {16'h0, count_value}, {16'h0, c0});
		@(posedge clk);
		cpu_idle <= 1'b0;
		measure(gap);
		check("idle resume", gap, 1);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check("wdt re-reset", {31'h0, watchdog_mode}, 32'h1);
		check("count re-reset", {16'h0, count_value}, 32'h0);
		apb(1'b1, `CA_ADDR_CNT_HIGH, 8'hAB);
		@(negedge clk);
		check("count locked", {24'h0, count_value[15:8]}, 32'h0);
		wrap_up();
	end
endmodule : counter_array_timebase_tb

// ==== core/counter_array_defs.svh ====
`ifndef COUNTER_ARRAY_DEFS_SVH
`define COUNTER_ARRAY_DEFS_SVH

// Register byte addresses
`define CA_ADDR_MODE      8'h00
`define CA_ADDR_CNT_LOW   8'h04
`define CA_ADDR_CNT_HIGH  8'h08
`define CA_ADDR_EXT_IE    8'h0C
`define CA_ADDR_IE        8'h10

// Mode register fields
`define CA_MODE_ECF       0
`define CA_MODE_SEL_LO    1
`define CA_MODE_SEL_HI    3
`define CA_MODE_FLAG      5
`define CA_MODE_WDT       6
`define CA_MODE_IDLE      7
`define CA_MODE_RESET     8'h40
`define CA_WDT_RESET      1'b1

// Enable register fields
`define CA_EXT_IE_ARRAY   0
`define CA_IE_GLOBAL      7

// Prescaler and counter terminal counts
`define CA_DIV12_LAST     4'hB
`define CA_DIV4_LAST      2'h3
`define CA_DIV8_LAST      3'h7
`define CA_COUNT_MAX      16'hFFFF

`endif

// ==== core/counter_array_pkg.sv ====
package counter_array_pkg;

	typedef enum logic [2:0] {
		TB_SYS_DIV12 = 3'b000,
		TB_SYS_DIV4  = 3'b001,
		TB_TIMER0    = 3'b010,
		TB_ECI_FALL  = 3'b011,
		TB_SYS       = 3'b100,
		TB_EXT_DIV8  = 3'b101,
		TB_RTC_DIV8  = 3'b110,
		TB_UNUSED    = 3'b111
	} timebase_type;

endpackage : counter_array_pkg

// ==== core/counter_array_timebase.sv ====
`timescale 1ns/1ns
`include "counter_array_defs.svh"

// Notes on behaviour
// [RQ1] Select 000 counts sysclk/12, 001 sysclk/4, 100 every sysclk.
// [RQ2] Select 010 counts Timer 0 overflows; 011 falling edges of count input.
// [RQ3] Selects 101/110 count external and RTC oscillators /8, synchronised first.
// [RQ4] Sixteen-bit counter seen by software as separate high and low bytes.
// [RQ5] Low byte read snapshots high byte; next high read returns snapshot.
// [RQ6] Reading counter bytes never disturbs counting.
// [RQ7] Wrap from all ones to zero sets the overflow flag.
// [RQ8] Overflow raises a request only while overflow interrupt enable is set.
// [RQ9] Overflow flag stays set until software clears it by a write.
// [RQ10] Request reaches processor only with global and array enables set.
// [RQ11] Idle control clear: counter runs on during processor idle.
// [RQ12] Counter value is shared with six capture/compare modules.
// [RQ13] Watchdog mode on after reset; restricts some register writes.
// [RQ14] Idle control set: counter holds during idle, resumes after.
// [RQ15] Count input passes two flops; falling edge gives one-cycle enable.

module counter_array_timebase (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        timer0_overflow,
	input  wire logic        external_count_input,
	input  wire logic        ext_osc_clk,
	input  wire logic        rtc_osc_clk,
	input  wire logic        cpu_idle,
	output logic      [15:0] count_value,
	output logic             watchdog_mode,
	output logic             irq_request
);

	logic [15:0] count_ff;
	logic [7:0]  snapshot_ff;
	logic [2:0]  sel_ff;
	logic        ecf_ff;
	logic        flag_ff;
	logic        wdt_ff;
	logic        idle_ctrl_ff;
	logic        array_ie_ff;
	logic        global_ie_ff;
	logic        irq_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic [31:0] prdata_ff;
	logic [3:0]  div12_ff;
	logic [1:0]  div4_ff;
	logic [2:0]  ext_div_ff;
	logic [2:0]  rtc_div_ff;
	logic        eci_fall;
	logic        ext_rise;
	logic        rtc_rise;
	logic        tick;
	logic        run;
	logic        take;
	logic        done_wr;
	logic        mapped;
	logic        wr_mode;
	logic        wr_low;
	logic        wr_high;
	logic        rd_low;
	logic [31:0] nxt_prdata;

	//////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	// [RQ15] synchronised falling edge
	pin_edge_sync u_eci_sync (
		.clk     (clk),
		.rst     (rst),
		.pin_in  (external_count_input),
		.rise_ff (),
		.fall_ff (eci_fall)
	);

	// [RQ3] oscillators into sysclk domain
	pin_edge_sync u_ext_sync (
		.clk     (clk),
		.rst     (rst),
		.pin_in  (ext_osc_clk),
		.rise_ff (ext_rise),
		.fall_ff ()
	);

	pin_edge_sync u_rtc_sync (
		.clk     (clk),
		.rst     (rst),
		.pin_in  (rtc_osc_clk),
		.rise_ff (rtc_rise),
		.fall_ff ()
	);

	//////////////////////////////////////////////////////////////////////
	// APB decode

	assign take    = psel & penable & ~pready_ff;
	assign done_wr = psel & penable & pready_ff & pwrite;
	assign mapped  = paddr == `CA_ADDR_MODE || paddr == `CA_ADDR_CNT_LOW ||
			paddr == `CA_ADDR_CNT_HIGH || paddr == `CA_ADDR_EXT_IE ||
			paddr == `CA_ADDR_IE;
	assign wr_mode = done_wr && paddr == `CA_ADDR_MODE;
	// [RQ13] counter writes locked in watchdog mode
	assign wr_low  = done_wr && paddr == `CA_ADDR_CNT_LOW && !wdt_ff;
	assign wr_high = done_wr && paddr == `CA_ADDR_CNT_HIGH && !wdt_ff;
	assign rd_low  = take && !pwrite && paddr == `CA_ADDR_CNT_LOW;

	// One wait state: ready rises the cycle after the access phase opens
	always_ff @(posedge clk) begin
		if (rst) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff  <= take;
			pslverr_ff <= take & ~mapped;
		end
	end

	always_comb begin
		nxt_prdata = 32'h0000_0000;
		case (paddr)
			`CA_ADDR_MODE: begin
				nxt_prdata[`CA_MODE_ECF]  = ecf_ff;
				nxt_prdata[`CA_MODE_SEL_HI:`CA_MODE_SEL_LO] = sel_ff;
				nxt_prdata[`CA_MODE_FLAG] = flag_ff;
				nxt_prdata[`CA_MODE_WDT]  = wdt_ff;
				nxt_prdata[`CA_MODE_IDLE] = idle_ctrl_ff;
			end
			`CA_ADDR_CNT_LOW:  nxt_prdata[7:0] = count_ff[7:0];
			// [RQ5] high read returns snapshot
			`CA_ADDR_CNT_HIGH: nxt_prdata[7:0] = snapshot_ff;
			`CA_ADDR_EXT_IE:
				nxt_prdata[`CA_EXT_IE_ARRAY] = array_ie_ff;
			`CA_ADDR_IE:
				nxt_prdata[`CA_IE_GLOBAL] = global_ie_ff;
			default: nxt_prdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prdata_ff <= 32'h0000_0000;
		end else if (take && !pwrite) begin
			prdata_ff <= nxt_prdata;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Control registers

	always_ff @(posedge clk) begin
		if (rst) begin
			ecf_ff       <= 1'b0;
			sel_ff       <= 3'h0;
			idle_ctrl_ff <= 1'b0;
			// [RQ13] watchdog on out of reset
			wdt_ff       <= `CA_WDT_RESET;
		end else if (wr_mode) begin
			ecf_ff <= pwdata[`CA_MODE_ECF];
			wdt_ff <= pwdata[`CA_MODE_WDT];
			// [RQ13] clock and idle setup locked in watchdog mode
			if (!wdt_ff) begin
				sel_ff <= pwdata[`CA_MODE_SEL_HI:`CA_MODE_SEL_LO];
				idle_ctrl_ff <= pwdata[`CA_MODE_IDLE];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			array_ie_ff  <= 1'b0;
			global_ie_ff <= 1'b0;
		end else if (done_wr) begin
			if (paddr == `CA_ADDR_EXT_IE)
				array_ie_ff <= pwdata[`CA_EXT_IE_ARRAY];
			if (paddr == `CA_ADDR_IE)
				global_ie_ff <= pwdata[`CA_IE_GLOBAL];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Timebase prescalers

	always_ff @(posedge clk) begin
		if (rst) begin
			div12_ff <= 4'h0;
			div4_ff  <= 2'h0;
		end else begin
			div12_ff <= (div12_ff == `CA_DIV12_LAST) ? 4'h0 : div12_ff + 4'h1;
			div4_ff  <= div4_ff + 2'h1;
		end
	end

	// [RQ3] divide synchronised oscillators by eight
	always_ff @(posedge clk) begin
		if (rst) begin
			ext_div_ff <= 3'h0;
			rtc_div_ff <= 3'h0;
		end else begin
			if (ext_rise)
				ext_div_ff <= ext_div_ff + 3'h1;
			if (rtc_rise)
				rtc_div_ff <= rtc_div_ff + 3'h1;
		end
	end

	// [RQ1] timebase select
	always_comb begin
		case (counter_array_pkg::timebase_type'(sel_ff))
			counter_array_pkg::TB_SYS_DIV12:
				tick = div12_ff == `CA_DIV12_LAST;
			counter_array_pkg::TB_SYS_DIV4:
				tick = div4_ff == `CA_DIV4_LAST;
			// [RQ2] timer 0 and count input
			counter_array_pkg::TB_TIMER0:  tick = timer0_overflow;
			counter_array_pkg::TB_ECI_FALL: tick = eci_fall;
			counter_array_pkg::TB_SYS:     tick = 1'b1;
			counter_array_pkg::TB_EXT_DIV8:
				tick = ext_rise && ext_div_ff == `CA_DIV8_LAST;
			counter_array_pkg::TB_RTC_DIV8:
				tick = rtc_rise && rtc_div_ff == `CA_DIV8_LAST;
			default: tick = 1'b0;
		endcase
	end

	// [RQ11] idle only stops counting when idle control set
	assign run = ~(idle_ctrl_ff & cpu_idle);

	//////////////////////////////////////////////////////////////////////
	// Counter, snapshot and overflow

	// [RQ4] byte writes; [RQ14] hold in idle
	always_ff @(posedge clk) begin
		if (rst) begin
			count_ff <= 16'h0000;
		end else if (wr_low) begin
			count_ff[7:0] <= pwdata[7:0];
		end else if (wr_high) begin
			count_ff[15:8] <= pwdata[7:0];
		end else if (tick && run) begin
			count_ff <= count_ff + 16'h0001;
		end
	end

	// [RQ5] low read latches high byte; [RQ6] count untouched
	always_ff @(posedge clk) begin
		if (rst) begin
			snapshot_ff <= 8'h00;
		end else if (rd_low) begin
			snapshot_ff <= count_ff[15:8];
		end
	end

	// [RQ7] set on wrap; [RQ9] write of zero clears, set wins
	always_ff @(posedge clk) begin
		if (rst) begin
			flag_ff <= 1'b0;
		end else if (tick && run && !wr_low && !wr_high &&
				count_ff == `CA_COUNT_MAX) begin
			flag_ff <= 1'b1;
		end else if (wr_mode && !pwdata[`CA_MODE_FLAG]) begin
			flag_ff <= 1'b0;
		end
	end

	// [RQ8] [RQ10] gated request
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= flag_ff & ecf_ff & array_ie_ff & global_ie_ff;
		end
	end

	// [RQ12] counter shared with the modules
	assign count_value   = count_ff;
	assign watchdog_mode = wdt_ff;
	assign irq_request   = irq_ff;
	assign prdata        = prdata_ff;
	assign pready        = pready_ff;
	assign pslverr       = pslverr_ff;

	//////////////////////////////////////////////////////////////////////
	// Checks

	property p_sysclk;
		@(posedge clk) disable iff (rst)
		(sel_ff == 3'b100 && run && !wr_low && !wr_high)
			|=> count_ff == $past(count_ff) + 16'h0001;
	endproperty
	a_sysclk: assert property (p_sysclk) // [RQ1]
		else $error("sysclk timebase missed a count");

	property p_div12;
		@(posedge clk) disable iff (rst)
		(sel_ff == counter_array_pkg::TB_SYS_DIV12 && tick)
			|=> (div12_ff != `CA_DIV12_LAST) [*8];
	endproperty
	a_div12: assert property (p_div12) // [RQ1]
		else $error("div12 tick too soon");

	property p_eci;
		@(posedge clk) disable iff (rst)
		(sel_ff == 3'b011 && eci_fall && run && !wr_low && !wr_high)
			|=> count_ff == $past(count_ff) + 16'h0001;
	endproperty
	a_eci: assert property (p_eci) // [RQ2]
		else $error("count input edge not counted");

	property p_overflow;
		@(posedge clk) disable iff (rst)
		(tick && run && count_ff == `CA_COUNT_MAX && !wr_low && !wr_high)
			|=> flag_ff && count_ff == 16'h0000;
	endproperty
	a_overflow: assert property (p_overflow) // [RQ7]
		else $error("wrap did not set overflow flag");

	property p_flag_hold;
		@(posedge clk) disable iff (rst)
		(flag_ff && !wr_mode) |=> flag_ff;
	endproperty
	a_flag_hold: assert property (p_flag_hold) // [RQ9]
		else $error("overflow flag cleared without write");

	property p_irq_gate;
		@(posedge clk) disable iff (rst)
		irq_ff |-> $past(flag_ff && ecf_ff && array_ie_ff && global_ie_ff);
	endproperty
	a_irq_gate: assert property (p_irq_gate) // [RQ10]
		else $error("request raised while gated off");

	property p_snapshot;
		@(posedge clk) disable iff (rst)
		rd_low |=> snapshot_ff == $past(count_ff[15:8]);
	endproperty
	a_snapshot: assert property (p_snapshot) // [RQ5]
		else $error("low read did not latch high byte");

	property p_idle_hold;
		@(posedge clk) disable iff (rst)
		(idle_ctrl_ff && cpu_idle && !wr_low && !wr_high) |=> $stable(count_ff);
	endproperty
	a_idle_hold: assert property (p_idle_hold) // [RQ14]
		else $error("counter moved during idle hold");

	property p_wdt_lock;
		@(posedge clk) disable iff (rst)
		(wdt_ff && wr_mode) |=> $stable(sel_ff) && $stable(idle_ctrl_ff);
	endproperty
	a_wdt_lock: assert property (p_wdt_lock) // [RQ13]
		else $error("setup changed in watchdog mode");

endmodule : counter_array_timebase

// ==== core/pin_edge_sync.sv ====
`timescale 1ns/1ns

module pin_edge_sync (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pin_in,
	output logic      rise_ff,
	output logic      fall_ff
);

	logic meta_ff;
	logic sync_ff;
	logic last_ff;

	// Two-stage synchroniser, then edge detect on the clean copy
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
			last_ff <= 1'b1;
		end else begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rise_ff <= 1'b0;
			fall_ff <= 1'b0;
		end else begin
			rise_ff <= sync_ff & ~last_ff;
			fall_ff <= ~sync_ff & last_ff;
		end
	end

endmodule : pin_edge_sync
